/* File: hdl/core_regs_pkg.sv */
package core_regs_pkg;

	// ==============================================================
	// Register widths.
	localparam int ADDR_WIDTH = 24;
	localparam int BYTE_WIDTH = 8;
	localparam int DATA_WIDTH = 32;

	// ==============================================================
	// Condition flag bit positions.
	localparam int FLAG_IRQ_MASK = 7;
	localparam int FLAG_SPARE_SIX = 6;
	localparam int FLAG_HALF = 5;
	localparam int FLAG_USER_FOUR = 4;
	localparam int FLAG_NEG = 3;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_OVF = 1;
	localparam int FLAG_CARRY = 0;

	// ==============================================================
	// Extended control field positions.
	localparam int EXT_TRACE = 7;
	localparam int EXT_RSVD_HI = 6;
	localparam int EXT_RSVD_LO = 3;
	localparam int EXT_LEVEL_HI = 2;

	// ==============================================================
	// Reset and fixed values.
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	localparam logic [7:0] EXT_RESET = 8'h7f;
	localparam logic [7:0] EXT_RSVD_ONES = 8'h78;
	localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 24'h000000;
	localparam logic [ADDR_WIDTH-1:0] INSN_BYTES = 24'h000002;

	// ==============================================================
	// Timing: interrupt blackout after an extended control write, in states.
	localparam int BLACKOUT_STATES = 3;
	localparam logic [1:0] BLACKOUT_LOAD = 2'(BLACKOUT_STATES);

	// ==============================================================
	// Operation encodings.
	typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} op_size_t;
	typedef enum logic [3:0] {
		KIND_ADD, KIND_ADDX, KIND_SUB, KIND_SUBX, KIND_CMP, KIND_NEG,
		KIND_LOGIC, KIND_SHIFT, KIND_BIT_LOAD, KIND_DEC_ADD, KIND_DEC_SUB
	} alu_kind_t;
	typedef enum logic [2:0] {CTL_LOAD, CTL_STORE, CTL_AND, CTL_OR, CTL_XOR} ctl_op_t;
	typedef enum logic [3:0] {
		COND_ALWAYS, COND_NEVER, COND_HI, COND_LS, COND_CC, COND_CS, COND_NE, COND_EQ,
		COND_VC, COND_VS, COND_PL, COND_MI, COND_GE, COND_LT, COND_GT, COND_LE
	} branch_cond_t;

endpackage : core_regs_pkg

/* File: hdl/core_link_if.sv */
// ==============================================================
// Carrier between the register file and its flag and branch helpers.
interface core_link_if;
	import core_regs_pkg::*;

	alu_kind_t kind; // Operation whose flags are wanted.
	op_size_t size; // Operand size.
	logic [DATA_WIDTH-1:0] opnd_a; // Destination operand.
	logic [DATA_WIDTH-1:0] opnd_b; // Source operand.
	logic carry_in; // Present carry flag.
	logic half_in; // Present half-carry flag.
	logic [2:0] bit_sel; // Bit number for bit loads.
	logic shift_out; // Bit shifted out by the shifter.
	logic [DATA_WIDTH-1:0] result; // Computed result.
	logic half, neg, zero, ovf, carry; // Computed flags.
	logic [3:0] cond; // Branch condition code.
	logic taken; // Branch condition holds.

	modport requester(output kind, size, opnd_a, opnd_b, carry_in, half_in, bit_sel, shift_out, cond,
		input result, half, neg, zero, ovf, carry, taken);
	modport calculator(input kind, size, opnd_a, opnd_b, carry_in, half_in, bit_sel, shift_out,
		output result, half, neg, zero, ovf, carry);
	modport evaluator(input cond, carry_in, neg, zero, ovf, output taken);

endinterface : core_link_if

/* File: hdl/flag_calculator.sv */
// ==============================================================
// Combinational result and flag computation.
module flag_calculator
	import core_regs_pkg::*;
(
	core_link_if.calculator lnk
);

	// Result width in bits for a size code.
	function automatic int size_bits(input op_size_t s);
		case (s)
			SIZE_BYTE: size_bits = 8;
			SIZE_WORD: size_bits = 16;
			default: size_bits = 32;
		endcase
	endfunction : size_bits

	// Arithmetic, half carry, sign, zero and overflow for the chosen size.
	always_comb begin
		logic [32:0] full;
		logic [31:0] x, y, msk, cx;
		logic sub, cin;
		int w;
		full = '0;
		x = '0;
		y = '0;
		cx = '0;
		sub = 1'b0;
		cin = 1'b0;
		w = size_bits(lnk.size);
		msk = (w == 32) ? 32'hffffffff : ((32'h00000001 << w) - 32'h00000001);
		lnk.result = '0;
		lnk.half = 1'b0;
		lnk.ovf = 1'b0;
		lnk.carry = lnk.carry_in;
		x = lnk.opnd_a & msk;
		y = lnk.opnd_b & msk;
		case (lnk.kind)
			KIND_ADD, KIND_ADDX: begin
				cin = (lnk.kind == KIND_ADDX) ? lnk.carry_in : 1'b0;
				full = {1'b0, x} + {1'b0, y} + {32'h00000000, cin};
			end
			KIND_SUB, KIND_SUBX, KIND_CMP, KIND_NEG: begin
				sub = 1'b1;
				cin = (lnk.kind == KIND_SUBX) ? lnk.carry_in : 1'b0;
				if (lnk.kind == KIND_NEG) begin
					y = x;
					x = '0;
				end
				full = {1'b0, x} - {1'b0, y} - {32'h00000000, cin};
			end
			KIND_LOGIC: full = {1'b0, x};
			KIND_SHIFT: begin
				full = {1'b0, x};
				lnk.carry = lnk.shift_out;
			end
			KIND_BIT_LOAD: begin
				full = {1'b0, x};
				lnk.carry = x[lnk.bit_sel];
			end
			KIND_DEC_ADD: begin
				// Byte treated as two packed BCD digits.
				cx = 32'h00000000;
				if (lnk.carry_in || x[7:0] > 8'h99) begin
					cx = 32'h00000060;
				end
				if (lnk.half_in || x[3:0] > 4'h9) begin
					cx = cx | 32'h00000006;
				end
				full = {1'b0, (x + cx) & 32'h000000ff};
				lnk.carry = lnk.carry_in || (x[7:0] > 8'h99);
			end
			KIND_DEC_SUB: begin
				cx = {24'h000000, (lnk.carry_in ? 8'h60 : 8'h00) | (lnk.half_in ? 8'h06 : 8'h00)};
				full = {1'b0, (x - cx) & 32'h000000ff};
				lnk.carry = lnk.carry_in;
			end
			default: full = {1'b0, x};
		endcase
		cx = x ^ y ^ full[31:0];
		lnk.result = full[31:0] & msk;
		if (lnk.kind inside {KIND_ADD, KIND_ADDX, KIND_SUB, KIND_SUBX, KIND_CMP, KIND_NEG}) begin
			// Carry or borrow into the top nibble of each size.
			case (lnk.size)
				SIZE_BYTE: lnk.half = cx[4];
				SIZE_WORD: lnk.half = cx[12];
				default: lnk.half = cx[28];
			endcase
			// Bit w of the widened sum is the carry out, or the borrow for a subtraction.
			lnk.carry = full[w];
			lnk.ovf = sub ? ((x[w-1] ^ y[w-1]) & (x[w-1] ^ full[w-1]))
				: (~(x[w-1] ^ y[w-1]) & (x[w-1] ^ full[w-1]));
		end
		lnk.neg = lnk.result[w-1];
		lnk.zero = (lnk.result == 32'h00000000);
	end

endmodule : flag_calculator

/* File: hdl/branch_condition_eval.sv */
// ==============================================================
// Conditional branch decision from the four arithmetic flags.
module branch_condition_eval
	import core_regs_pkg::*;
(
	core_link_if.evaluator lnk
);

	// Standard sixteen-way condition table.
	always_comb begin
		case (branch_cond_t'(lnk.cond))
			COND_ALWAYS: lnk.taken = 1'b1;
			COND_NEVER: lnk.taken = 1'b0;
			COND_HI: lnk.taken = ~(lnk.carry_in | lnk.zero);
			COND_LS: lnk.taken = lnk.carry_in | lnk.zero;
			COND_CC: lnk.taken = ~lnk.carry_in;
			COND_CS: lnk.taken = lnk.carry_in;
			COND_NE: lnk.taken = ~lnk.zero;
			COND_EQ: lnk.taken = lnk.zero;
			COND_VC: lnk.taken = ~lnk.ovf;
			COND_VS: lnk.taken = lnk.ovf;
			COND_PL: lnk.taken = ~lnk.neg;
			COND_MI: lnk.taken = lnk.neg;
			COND_GE: lnk.taken = ~(lnk.neg ^ lnk.ovf);
			COND_LT: lnk.taken = lnk.neg ^ lnk.ovf;
			COND_GT: lnk.taken = ~(lnk.zero | (lnk.neg ^ lnk.ovf));
			COND_LE: lnk.taken = lnk.zero | (lnk.neg ^ lnk.ovf);
			default: lnk.taken = 1'b0;
		endcase
	end

endmodule : branch_condition_eval

/* File: hdl/cpu_control_status_registers.sv */
// Function
// - 24-bit address counter, fetch bit zero cleared
// - Trace flag raises exception per instruction
// - Extended bits six to three read one
// - Three-bit priority mask level to interrupts
// - Extended control writes block all interrupts three states
// - Flag bit seven masks all but non-maskable
// - Exception start sets interrupt mask bit
// - Bit six plain user bit, no masking
// - Byte half carry from bit three
// - Word half carry from bit eleven
// - Longword half carry from bit 27
// - Negative flag takes result sign bit
// - Zero flag set on zero result
// - Overflow flag set on arithmetic overflow
// - Carry records carry, borrow, shift, bit accumulator
// - Branches use negative, zero, overflow, carry
// - Control instructions read and modify flags
// - Reset: vector fetch, trace clear, masks set
// - Bit ops address bits 0-7; packed BCD
module cpu_control_status_registers
	import core_regs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	// ==============================================================
	// Instruction sequencing.
	input wire logic vector_load, // Load the counter from the reset vector.
	input wire logic [ADDR_WIDTH-1:0] vector_addr, // Vector table entry.
	input wire logic pc_advance, // Step past one two-byte instruction.
	input wire logic pc_jump, // Load a branch target.
	input wire logic [ADDR_WIDTH-1:0] jump_addr, // Branch target.
	input wire logic insn_done, // One instruction has finished.
	input wire logic exception_start, // An exception sequence begins.
	output logic [ADDR_WIDTH-1:0] fetch_addr_q, // Address of the next fetch.
	output logic trace_request_q, // Trace exception wanted.
	// ==============================================================
	// Control-register instructions.
	input wire logic ctl_valid, // A control instruction executes.
	input wire ctl_op_t ctl_op, // Which control instruction.
	input wire logic ctl_target_ext, // One for extended control, zero for flags.
	input wire logic [BYTE_WIDTH-1:0] ctl_operand, // Immediate or source byte.
	output logic [BYTE_WIDTH-1:0] ctl_read_q, // Value read by a store.
	output logic [BYTE_WIDTH-1:0] flags_q, // Condition flags as held.
	output logic [BYTE_WIDTH-1:0] ext_q, // Extended control as read.
	output logic [2:0] priority_mask_level_q, // Level mask for the interrupt logic.
	// ==============================================================
	// Flag updates from the execution unit.
	input wire logic alu_valid, // Operands below are valid this cycle.
	input wire alu_kind_t alu_kind, // Operation.
	input wire op_size_t alu_size, // Size.
	input wire logic [DATA_WIDTH-1:0] alu_a, // Destination operand.
	input wire logic [DATA_WIDTH-1:0] alu_b, // Source operand.
	input wire logic [2:0] alu_bit_sel, // Bit number.
	input wire logic alu_shift_out, // Bit leaving the shifter.
	input wire logic [5:0] alu_keep, // Ones keep half, user four, N, Z, V, C.
	output logic [DATA_WIDTH-1:0] alu_result_q, // Registered result.
	// ==============================================================
	// Branch and interrupt acceptance.
	input wire logic [3:0] branch_cond, // Condition of a conditional branch.
	output logic branch_taken_q, // Condition held, sampled each cycle.
	input wire logic irq_request, // Maskable request pending.
	input wire logic [2:0] irq_level, // Level of that request.
	input wire logic nmi_request, // Non-maskable request pending.
	output logic irq_accept_q, // Maskable request may be taken.
	output logic nmi_accept_q // Non-maskable request may be taken.
);

	// ==============================================================
	// State.
	logic [ADDR_WIDTH-1:0] pc_q; // Instruction address counter.
	logic [BYTE_WIDTH-1:0] cf_q; // Condition flags.
	logic trace_q; // Trace flag.
	logic [2:0] level_q; // Priority mask level.
	logic [1:0] blackout_q; // Remaining blocked states.
	logic [BYTE_WIDTH-1:0] ext_view; // Extended control as software sees it.
	logic [BYTE_WIDTH-1:0] ctl_src; // Register addressed by a control op.
	logic [BYTE_WIDTH-1:0] ctl_new; // Value a control op writes.
	logic ctl_writes; // Control op modifies its target.

	// ==============================================================
	// Helpers.
	core_link_if lnk ();

	// Flag computation for the execution unit.
	flag_calculator u_flags (
		.lnk(lnk.calculator)
	);

	// Branch decision on the calculator's N, Z and V with the held carry.
	branch_condition_eval u_branch (
		.lnk(lnk.evaluator)
	);

	// Drive the helper inputs from the ports and held flags.
	assign lnk.kind = alu_kind;
	assign lnk.size = alu_size;
	assign lnk.opnd_a = alu_a;
	assign lnk.opnd_b = alu_b;
	assign lnk.bit_sel = alu_bit_sel;
	assign lnk.shift_out = alu_shift_out;
	assign lnk.carry_in = cf_q[FLAG_CARRY];
	assign lnk.half_in = cf_q[FLAG_HALF];
	assign lnk.cond = branch_cond;

	// Branch evaluation reads the held flags, not the calculator's fresh ones.
	// The evaluator shares neg, zero and ovf with the calculator only by name, so
	// they are re-sourced here through a second view.
	core_link_if blnk ();
	assign blnk.cond = branch_cond;
	assign blnk.carry_in = cf_q[FLAG_CARRY];
	assign blnk.neg = cf_q[FLAG_NEG];
	assign blnk.zero = cf_q[FLAG_ZERO];
	assign blnk.ovf = cf_q[FLAG_OVF];
	assign blnk.kind = KIND_LOGIC;
	assign blnk.size = SIZE_BYTE;
	assign blnk.opnd_a = '0;
	assign blnk.opnd_b = '0;
	assign blnk.bit_sel = '0;
	assign blnk.shift_out = 1'b0;
	assign blnk.half_in = 1'b0;
	assign blnk.result = '0;
	assign blnk.half = 1'b0;

	// The second evaluator is the one whose answer is used.
	branch_condition_eval u_branch_held (
		.lnk(blnk.evaluator)
	);

	// ==============================================================
	// Control-instruction decode.

	// Reserved extended bits always read as ones.
	always_comb begin
		ext_view = EXT_RSVD_ONES;
		ext_view[EXT_TRACE] = trace_q;
		ext_view[EXT_LEVEL_HI:0] = level_q;
	end

	// Compute what a load, AND, OR or XOR leaves in the target.
	always_comb begin
		ctl_src = ctl_target_ext ? ext_view : cf_q;
		ctl_writes = ctl_valid && (ctl_op != CTL_STORE);
		case (ctl_op)
			CTL_LOAD: ctl_new = ctl_operand;
			CTL_AND: ctl_new = ctl_src & ctl_operand;
			CTL_OR: ctl_new = ctl_src | ctl_operand;
			CTL_XOR: ctl_new = ctl_src ^ ctl_operand;
			default: ctl_new = ctl_src;
		endcase
	end

	// ==============================================================
	// Instruction address counter.

	// Reset leaves zero until the vector is loaded; a jump beats a step.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= ADDR_RESET;
		end else if (vector_load) begin
			pc_q <= vector_addr;
		end else if (pc_jump) begin
			pc_q <= jump_addr;
		end else if (pc_advance) begin
			pc_q <= pc_q + INSN_BYTES;
		end
	end

	// Fetch address with the low bit forced to zero, since instructions are words.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetch_addr_q <= ADDR_RESET;
		end else begin
			fetch_addr_q <= {pc_q[ADDR_WIDTH-1:1], 1'b0};
		end
	end

	// ==============================================================
	// Extended control register.

	// Trace and level fields; reserved bits are not stored at all.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trace_q <= EXT_RESET[EXT_TRACE];
			level_q <= EXT_RESET[EXT_LEVEL_HI:0];
		end else if (ctl_writes && ctl_target_ext) begin
			trace_q <= ctl_new[EXT_TRACE];
			level_q <= ctl_new[EXT_LEVEL_HI:0];
		end
	end

	// Blackout counter: a write to extended control blocks every interrupt for a
	// few states so that the new level settles before anything is taken.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blackout_q <= 2'h0;
		end else if (ctl_writes && ctl_target_ext) begin
			blackout_q <= BLACKOUT_LOAD;
		end else if (blackout_q != 2'h0) begin
			blackout_q <= blackout_q - 2'h1;
		end
	end

	// ==============================================================
	// Condition flags.

	// Priority: exception start sets the mask over anything else; a control
	// write beats an execution-unit update in the same cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cf_q <= FLAGS_RESET;
		end else begin
			if (ctl_writes && !ctl_target_ext) begin
				cf_q <= ctl_new;
			end else if (alu_valid) begin
				// Half, N, Z, V and C each move unless the instruction keeps them; user four never moves.
				if (!alu_keep[5]) begin
					cf_q[FLAG_HALF] <= lnk.half;
				end
				if (!alu_keep[3]) begin
					cf_q[FLAG_NEG] <= lnk.neg;
				end
				if (!alu_keep[2]) begin
					cf_q[FLAG_ZERO] <= lnk.zero;
				end
				if (!alu_keep[1]) begin
					cf_q[FLAG_OVF] <= lnk.ovf;
				end
				if (!alu_keep[0]) begin
					cf_q[FLAG_CARRY] <= lnk.carry;
				end
			end
			if (exception_start) begin
				cf_q[FLAG_IRQ_MASK] <= 1'b1;
			end
		end
	end

	// ==============================================================
	// Registered outputs.

	// Store result and register views.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_read_q <= 8'h00;
			flags_q <= FLAGS_RESET;
			ext_q <= EXT_RESET;
			priority_mask_level_q <= EXT_RESET[EXT_LEVEL_HI:0];
		end else begin
			if (ctl_valid && ctl_op == CTL_STORE) begin
				ctl_read_q <= ctl_src;
			end
			flags_q <= cf_q;
			ext_q <= ext_view;
			priority_mask_level_q <= level_q;
		end
	end

	// Execution result and branch decision.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alu_result_q <= '0;
			branch_taken_q <= 1'b0;
		end else begin
			if (alu_valid) begin
				alu_result_q <= lnk.result;
			end
			branch_taken_q <= blnk.taken;
		end
	end

	// Trace request follows each finished instruction while tracing.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trace_request_q <= 1'b0;
		end else begin
			trace_request_q <= insn_done && trace_q;
		end
	end

	// ==============================================================
	// Interrupt acceptance.

	// The flag mask and the level mask both gate maskable requests; only the
	// blackout stops the non-maskable one. Bit six plays no part here.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_accept_q <= 1'b0;
			nmi_accept_q <= 1'b0;
		end else begin
			irq_accept_q <= irq_request && !cf_q[FLAG_IRQ_MASK] && (irq_level > level_q)
				&& (blackout_q == 2'h0);
			nmi_accept_q <= nmi_request && (blackout_q == 2'h0);
		end
	end

	// A store does not write, so it never starts a blackout; software must still
	// set up the stack pointer itself after reset, nothing here does so.

endmodule : cpu_control_status_registers

/* File: tb/cpu_control_status_registers_properties.sv */
// ==============================================================
// Port-level checks of the control and status registers.
module ctl_status_checker
	import core_regs_pkg::*;
(
	input logic clk,
	input logic resetn,
	input logic insn_done,
	input logic exception_start,
	input logic ctl_valid,
	input ctl_op_t ctl_op,
	input logic ctl_target_ext,
	input logic [3:0] branch_cond,
	input logic irq_request,
	input logic [2:0] irq_level,
	input logic nmi_request,
	input logic [ADDR_WIDTH-1:0] fetch_addr_q,
	input logic trace_request_q,
	input logic [BYTE_WIDTH-1:0] flags_q,
	input logic [BYTE_WIDTH-1:0] ext_q,
	input logic [2:0] priority_mask_level_q,
	input logic branch_taken_q,
	input logic irq_accept_q,
	input logic nmi_accept_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// A write of extended control opens the interrupt blackout; a store does not.
	logic ext_wr;
	assign ext_wr = ctl_valid && ctl_target_ext && ctl_op != CTL_STORE;
	AST_FETCH_EVEN: assert property (fetch_addr_q[0] == 1'b0)
		else $error("odd fetch address");
	AST_RESET_VIEW: assert property ($rose(resetn) |-> flags_q == 8'h80 && ext_q == 8'h7f)
		else $error("wrong values after reset");
	AST_RSVD_ONES: assert property (ext_q[6:3] == 4'hf)
		else $error("reserved bits not one");
	AST_LEVEL_VIEW: assert property (priority_mask_level_q == ext_q[2:0])
		else $error("mask level differs from register");
	AST_TRACE: assert property (trace_request_q == ($past(insn_done) && ext_q[7]))
		else $error("trace request wrong");
	AST_BLACKOUT: assert property (ext_wr |=> ##1 (!nmi_accept_q && !irq_accept_q) [*3])
		else $error("interrupt accepted in blackout");
	AST_EXC_MASK: assert property (exception_start |=> ##1 flags_q[7])
		else $error("exception did not set mask");
	AST_IRQ_GATE: assert property (irq_accept_q |-> $past(irq_request) && !flags_q[7] &&
		$past(irq_level) > priority_mask_level_q)
		else $error("maskable request accepted while masked");
	AST_NMI_CAUSE: assert property (nmi_accept_q |-> $past(nmi_request))
		else $error("nmi accepted without request");
	AST_BR_ALWAYS: assert property (resetn && branch_cond == 4'h0 |=> branch_taken_q)
		else $error("always branch not taken");
	AST_BR_NEVER: assert property (branch_cond == 4'h1 |=> !branch_taken_q)
		else $error("never branch taken");
endmodule : ctl_status_checker

bind cpu_control_status_registers ctl_status_checker chk (.clk, .resetn, .insn_done, .exception_start,
	.ctl_valid, .ctl_op, .ctl_target_ext, .branch_cond, .irq_request, .irq_level, .nmi_request, .fetch_addr_q,
	.trace_request_q, .flags_q, .ext_q, .priority_mask_level_q, .branch_taken_q, .irq_accept_q, .nmi_accept_q);

/* File: tb/test_cpu_control_status_registers.sv */
// ==============================================================
// Self-checking bench: every input driven at the rising edge.
module test_cpu_control_status_registers;
	import core_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, vector_load, pc_advance, pc_jump, insn_done, exception_start, ctl_valid, ctl_target_ext;
	logic alu_valid, alu_shift_out, branch_taken_q, irq_request, nmi_request, irq_accept_q, nmi_accept_q;
	logic trace_request_q;
	logic [ADDR_WIDTH-1:0] vector_addr, jump_addr, fetch_addr_q;
	ctl_op_t ctl_op;
	logic [7:0] ctl_operand, ctl_read_q, flags_q, ext_q;
	logic [2:0] priority_mask_level_q, alu_bit_sel, irq_level;
	alu_kind_t alu_kind;
	op_size_t alu_size;
	logic [31:0] alu_a, alu_b, alu_result_q;
	logic [5:0] alu_keep;
	logic [3:0] branch_cond;
	int err_count, n_checks;
	typedef ctl_op_t op5_t[5];
	typedef logic [7:0] byte5_t[5];

	cpu_control_status_registers DUT (.clk, .resetn, .vector_load, .vector_addr, .pc_advance, .pc_jump,
		.jump_addr, .insn_done, .exception_start, .fetch_addr_q, .trace_request_q, .ctl_valid, .ctl_op,
		.ctl_target_ext, .ctl_operand, .ctl_read_q, .flags_q, .ext_q, .priority_mask_level_q, .alu_valid,
		.alu_kind, .alu_size, .alu_a, .alu_b, .alu_bit_sel, .alu_shift_out, .alu_keep, .alu_result_q,
		.branch_cond, .branch_taken_q, .irq_request, .irq_level, .nmi_request, .irq_accept_q, .nmi_accept_q);

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==============================================================
	// Shared helpers.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Lets the edge's updates land before anything is sampled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// Reset is held for 16 cycles; a second call checks a mid-run reset.
	task automatic do_reset;
		@(posedge clk);
		resetn <= 1'b0;
		tick(15);
		chk("flags", 8'h80, flags_q);
		chk("ext", 8'h7f, ext_q);
		@(posedge clk);
		resetn <= 1'b1;
		tick(2);
		chk("level", 3'h7, priority_mask_level_q);
	endtask : do_reset

	// One control instruction, then three edges so the accept outputs still show the blackout.
	task automatic ctl1(input ctl_op_t op, input logic ext, input logic [7:0] val);
		@(posedge clk);
		ctl_valid <= 1'b1;
		ctl_op <= op;
		ctl_target_ext <= ext;
		ctl_operand <= val;
		@(posedge clk);
		ctl_valid <= 1'b0;
		tick(3);
	endtask : ctl1

	task automatic run_ctl(input logic ext, input op5_t ops, input byte5_t val, input byte5_t exp);
		for (int i = 0; i < 5; i++) begin
			ctl1(ops[i], ext, val[i]);
			chk("view", exp[i], ext ? ext_q : flags_q);
			chk("nmi", !(ext && ops[i] != CTL_STORE), nmi_accept_q);
		end
		chk("store", exp[4], ctl_read_q);
	endtask : run_ctl

	task automatic trace_pulse(input logic exp);
		@(posedge clk);
		insn_done <= 1'b1;
		@(posedge clk);
		insn_done <= 1'b0;
		#1;
		chk("trace", exp, trace_request_q);
		tick(1);
		chk("trace end", 1'b0, trace_request_q);
	endtask : trace_pulse

	// Results compare on the low size bits; shifts take their out bit from b.
	task automatic alu(input alu_kind_t k, input op_size_t s, input logic [31:0] a, input logic [31:0] b,
		input logic [2:0] sel, input logic [5:0] keep, input logic [4:0] m, input logic [4:0] f, input logic [31:0] r);
		logic [31:0] rm;
		rm = s == SIZE_BYTE ? 32'hff : s == SIZE_WORD ? 32'hffff : 32'hffffffff;
		@(posedge clk);
		alu_valid <= 1'b1;
		alu_kind <= k;
		alu_size <= s;
		alu_a <= a;
		alu_b <= b;
		alu_bit_sel <= sel;
		alu_shift_out <= b[0];
		alu_keep <= keep;
		@(posedge clk);
		alu_valid <= 1'b0;
		tick(2);
		chk("hnzvc", f & m, {flags_q[5], flags_q[3:0]} & m);
		if (k <= KIND_NEG) chk("result", r, alu_result_q & rm);
	endtask : alu

	// ==============================================================
	// Scenarios.
	task automatic t_pc;
		@(posedge clk);
		vector_load <= 1'b1;
		vector_addr <= 24'h123457;
		pc_advance <= 1'b1;
		@(posedge clk);
		vector_load <= 1'b0;
		@(posedge clk);
		pc_advance <= 1'b0;
		#1;
		chk("fetch", 24'h123456, fetch_addr_q);
		tick(1);
		chk("fetch", 24'h123458, fetch_addr_q);
		@(posedge clk) pc_jump <= 1'b1;
		pc_advance <= 1'b1;
		jump_addr <= 24'h00abc1;
		@(posedge clk);
		pc_jump <= 1'b0;
		pc_advance <= 1'b0;
		tick(2);
		chk("fetch", 24'h00abc0, fetch_addr_q);
	endtask : t_pc

	task automatic t_alu;
		alu(KIND_ADD, SIZE_BYTE, 32'h0f, 32'h01, 3'h0, 6'h00, 5'h1f, 5'h10, 32'h10);
		alu(KIND_ADD, SIZE_WORD, 32'h0fff, 32'h1, 3'h0, 6'h00, 5'h1f, 5'h10, 32'h1000);
		alu(KIND_ADD, SIZE_LONG, 32'h0fffffff, 32'h1, 3'h0, 6'h00, 5'h1f, 5'h10, 32'h10000000);
		alu(KIND_ADD, SIZE_BYTE, 32'h7f, 32'h01, 3'h0, 6'h00, 5'h1f, 5'h1a, 32'h80);
		alu(KIND_SUB, SIZE_BYTE, 32'h80, 32'h01, 3'h0, 6'h00, 5'h1f, 5'h12, 32'h7f);
		alu(KIND_ADD, SIZE_BYTE, 32'hff, 32'h01, 3'h0, 6'h00, 5'h1f, 5'h15, 32'h00);
		alu(KIND_ADD, SIZE_BYTE, 32'h01, 32'h01, 3'h0, 6'h3f, 5'h1f, 5'h15, 32'h02);
		alu(KIND_ADDX, SIZE_BYTE, 32'h0f, 32'h00, 3'h0, 6'h00, 5'h1f, 5'h10, 32'h10);
		alu(KIND_SUB, SIZE_BYTE, 32'h00, 32'h01, 3'h0, 6'h00, 5'h1f, 5'h19, 32'hff);
		alu(KIND_CMP, SIZE_WORD, 32'h1000, 32'h1, 3'h0, 6'h00, 5'h1f, 5'h10, 32'h0fff);
		alu(KIND_NEG, SIZE_LONG, 32'h1, 32'h0, 3'h0, 6'h00, 5'h1f, 5'h19, 32'hffffffff);
		alu(KIND_SHIFT, SIZE_BYTE, 32'h0, 32'h0, 3'h0, 6'h00, 5'h01, 5'h00, 32'h0);
		alu(KIND_DEC_ADD, SIZE_BYTE, 32'h9a, 32'h0, 3'h0, 6'h00, 5'h1f, 5'h05, 32'h0);
		alu(KIND_BIT_LOAD, SIZE_BYTE, 32'h08, 32'h0, 3'h3, 6'h00, 5'h01, 5'h01, 32'h0);
		alu(KIND_BIT_LOAD, SIZE_BYTE, 32'h08, 32'h0, 3'h2, 6'h00, 5'h01, 5'h00, 32'h0);
		alu(KIND_SHIFT, SIZE_BYTE, 32'h0, 32'h1, 3'h0, 6'h00, 5'h01, 5'h01, 32'h0);
	endtask : t_alu

	// Each flag pattern makes one condition true and its neighbour code false.
	task automatic t_branch;
		logic [7:0] fl[8] = '{8'h04, 8'h01, 8'h08, 8'h02, 8'h00, 8'h08, 8'h01, 8'h00};
		logic [3:0] ct[8] = '{4'h7, 4'h5, 4'hb, 4'h9, 4'he, 4'hf, 4'h3, 4'hc};
		for (int i = 0; i < 8; i++) begin
			ctl1(CTL_LOAD, 1'b0, fl[i]);
			@(posedge clk) branch_cond <= ct[i];
			tick(2);
			chk("taken", 1'b1, branch_taken_q);
			@(posedge clk) branch_cond <= ct[i] - 4'h1;
			tick(2);
			chk("not taken", 1'b0, branch_taken_q);
		end
		@(posedge clk) branch_cond <= 4'h1;
		tick(2);
		@(posedge clk) branch_cond <= 4'h0;
	endtask : t_branch

	task automatic t_irq;
		irq_request <= 1'b1;
		irq_level <= 3'h3;
		ctl1(CTL_LOAD, 1'b1, 8'h00);
		trace_pulse(1'b0);
		ctl1(CTL_LOAD, 1'b0, 8'h80);
		chk("irq masked", 1'b0, irq_accept_q);
		chk("nmi", 1'b1, nmi_accept_q);
		ctl1(CTL_LOAD, 1'b0, 8'h40);
		chk("irq bit six", 1'b1, irq_accept_q);
		ctl1(CTL_LOAD, 1'b1, 8'h03);
		tick(1);
		chk("irq level equal", 1'b0, irq_accept_q);
		ctl1(CTL_LOAD, 1'b1, 8'h02);
		tick(1);
		chk("irq level above", 1'b1, irq_accept_q);
		@(posedge clk) exception_start <= 1'b1;
		@(posedge clk);
		exception_start <= 1'b0;
		tick(2);
		chk("exception mask", 1'b1, flags_q[7]);
		chk("irq after exception", 1'b0, irq_accept_q);
	endtask : t_irq
	// Watchdog: the whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		{resetn, vector_load, pc_advance, pc_jump, insn_done, exception_start, ctl_valid} = 7'h00;
		{ctl_target_ext, alu_valid, alu_shift_out, irq_request, irq_level, alu_bit_sel} = 10'h000;
		{vector_addr, jump_addr, ctl_operand, alu_a, alu_b, alu_keep, branch_cond} = 130'h0;
		ctl_op = CTL_LOAD;
		alu_kind = KIND_ADD;
		alu_size = SIZE_BYTE;
		nmi_request = 1'b1;
		do_reset();
		t_pc();
		run_ctl(1'b1, '{CTL_LOAD, CTL_AND, CTL_XOR, CTL_OR, CTL_STORE}, '{8'h05, 8'h7a, 8'h03, 8'h80, 8'h00},
			'{8'h7d, 8'h78, 8'h7b, 8'hfb, 8'hfb});
		trace_pulse(1'b1);
		run_ctl(1'b0, '{CTL_LOAD, CTL_OR, CTL_XOR, CTL_AND, CTL_STORE}, '{8'h50, 8'h01, 8'hc0, 8'h5f, 8'h00},
			'{8'h50, 8'h51, 8'h91, 8'h11, 8'h11});
		t_alu();
		t_branch();
		t_irq();
		do_reset();
		tally_and_finish();
	end
endmodule : test_cpu_control_status_registers
